/* rtl/rsc_reset_source_control.sv */
// Reset source selection, cause recording and release sequencing
`timescale 1ns/1ps
module rsc_reset_source_control
  import rsc_pkg::*;
#(
  parameter int MCD_CYCLES = MCD_TIMEOUT_CYC
) (
  // Clock and power-on reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic       sfr_rmw,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Reset sources
  input  wire logic       rst_pin_in_b,
  input  wire logic       usb_bus_reset,
  input  wire logic       vbus_level,
  input  wire logic       bus_supply_polarity_select,
  input  wire logic       comparator_out,
  input  wire logic       watchdog_timeout,
  input  wire logic       memory_access_error,
  input  wire logic       supply_below_threshold,
  input  wire logic       sysclk_edge_toggle,
  // External reset pin drive
  output logic            rst_pin_out,
  output logic            rst_pin_oe_b,
  // Core reset
  output logic            core_reset_b
);
  localparam int SYN_W   = 5;
  localparam int S_PIN   = 0;
  localparam int S_VBUS  = 1;
  localparam int S_CMP   = 2;
  localparam int S_VDD   = 3;
  localparam int S_TICK  = 4;
  localparam logic [SYN_W-1:0] SYN_RST = 5'h05;

  // Input synchronisers
  logic [SYN_W-1:0] sync1_ff;
  logic [SYN_W-1:0] sync2_ff;
  logic             tick_d_ff;
  // Sequencer and register state
  rsc_state_t       state_ff;
  rsc_state_t       nxt_state;
  logic [7:0]       cause_ff;
  logic [7:0]       nxt_cause;
  logic             usb_en_ff;
  logic             nxt_usb_en;
  logic             cmp_en_ff;
  logic             nxt_cmp_en;
  logic             mcd_en_ff;
  logic             nxt_mcd_en;
  logic             vdd_sel_ff;
  logic             nxt_vdd_sel;
  logic [7:0]       rdata_ff;
  logic [7:0]       nxt_rdata;
  logic             core_rst_b_ff;
  // Combinational helpers
  logic             reg_hit;
  logic             wr_hit;
  logic             pin_done;
  logic             mcd_done;
  logic             dly_done;
  logic             clk_edge_seen;
  logic [7:0]       src_vec;
  logic [7:0]       src_pick;

  assign reg_hit       = (sfr_addr == RSC_ADDR);
  assign wr_hit        = sfr_wr && reg_hit;
  assign clk_edge_seen = sync2_ff[S_TICK] ^ tick_d_ff;
  assign sfr_rdata     = rdata_ff;
  assign core_reset_b  = core_rst_b_ff;
  assign rst_pin_out   = 1'b0;
  assign rst_pin_oe_b  = 1'b1;

  // Pin low qualification
  rsc_cnt #(.WIDTH(PIN_CNT_W), .LIMIT(PIN_CNT_W'(PIN_LOW_CYC))) u_pin_cnt (
    .clk   (clk),
    .rst_b (rst_b),
    .clear (sync2_ff[S_PIN]),
    .done  (pin_done)
  );

  // Clock loss timeout
  rsc_cnt #(.WIDTH(MCD_CNT_W), .LIMIT(MCD_CNT_W'(MCD_CYCLES))) u_mcd_cnt (
    .clk   (clk),
    .rst_b (rst_b),
    .clear (!mcd_en_ff || clk_edge_seen || (state_ff != RSC_RUN)),
    .done  (mcd_done)
  );

  // Release delay
  rsc_cnt #(.WIDTH(DLY_CNT_W), .LIMIT(DLY_CNT_W'(EXEC_DELAY_CYC))) u_dly_cnt (
    .clk   (clk),
    .rst_b (rst_b),
    .clear (state_ff != RSC_DELAY),
    .done  (dly_done)
  );

  // Active reset requests in register bit order
  always_comb begin
    src_vec          = NO_CAUSE;
    src_vec[USB_BIT] = usb_en_ff && (usb_bus_reset ||
                       (sync2_ff[S_VBUS] == bus_supply_polarity_select));
    src_vec[MEM_BIT] = memory_access_error;
    src_vec[CMP_BIT] = cmp_en_ff && !sync2_ff[S_CMP];
    src_vec[SW_BIT]  = wr_hit && sfr_wdata[SW_BIT];
    src_vec[WDT_BIT] = watchdog_timeout;
    src_vec[MCD_BIT] = mcd_en_ff && mcd_done;
    src_vec[POR_BIT] = vdd_sel_ff && sync2_ff[S_VDD];
    src_vec[PIN_BIT] = pin_done;
  end

  // Priority pick, one cause only
  always_comb begin
    src_pick = NO_CAUSE;
    if (src_vec[POR_BIT]) begin
      src_pick[POR_BIT] = 1'b1;
    end else if (src_vec[PIN_BIT]) begin
      src_pick[PIN_BIT] = 1'b1;
    end else if (src_vec[MCD_BIT]) begin
      src_pick[MCD_BIT] = 1'b1;
    end else if (src_vec[MEM_BIT]) begin
      src_pick[MEM_BIT] = 1'b1;
    end else if (src_vec[WDT_BIT]) begin
      src_pick[WDT_BIT] = 1'b1;
    end else if (src_vec[SW_BIT]) begin
      src_pick[SW_BIT] = 1'b1;
    end else if (src_vec[CMP_BIT]) begin
      src_pick[CMP_BIT] = 1'b1;
    end else if (src_vec[USB_BIT]) begin
      src_pick[USB_BIT] = 1'b1;
    end
  end

  // Sequencer, cause flags, enables and read data
  always_comb begin
    nxt_state   = state_ff;
    nxt_cause   = cause_ff;
    nxt_usb_en  = usb_en_ff;
    nxt_cmp_en  = cmp_en_ff;
    nxt_mcd_en  = mcd_en_ff;
    nxt_vdd_sel = vdd_sel_ff;
    nxt_rdata   = rdata_ff;
    case (state_ff)
      RSC_RUN: begin
        if (src_vec != NO_CAUSE) begin
          nxt_state  = RSC_HOLD;
          nxt_cause  = src_pick;
          nxt_usb_en = 1'b0;
          nxt_cmp_en = 1'b0;
          nxt_mcd_en = 1'b0;
        end else if (wr_hit) begin
          nxt_usb_en  = sfr_wdata[USB_BIT];
          nxt_cmp_en  = sfr_wdata[CMP_BIT];
          nxt_mcd_en  = sfr_wdata[MCD_BIT];
          nxt_vdd_sel = sfr_wdata[POR_BIT];
        end
      end
      RSC_HOLD: begin
        if (src_vec == NO_CAUSE) begin
          nxt_state = RSC_DELAY;
        end
      end
      RSC_DELAY: begin
        if (src_vec != NO_CAUSE) begin
          nxt_state = RSC_HOLD;
        end else if (dly_done) begin
          nxt_state = RSC_RUN;
        end
      end
      default: begin
        nxt_state = RSC_HOLD;
      end
    endcase
    if (sfr_rd) begin
      if (!reg_hit) begin
        nxt_rdata = NO_CAUSE;
      end else if (sfr_rmw) begin
        nxt_rdata = cause_ff;
        nxt_rdata[USB_BIT] = usb_en_ff;
        nxt_rdata[CMP_BIT] = cmp_en_ff;
        nxt_rdata[SW_BIT]  = 1'b0;
        nxt_rdata[MCD_BIT] = mcd_en_ff;
        nxt_rdata[POR_BIT] = vdd_sel_ff;
      end else begin
        nxt_rdata = cause_ff;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_ff      <= SYN_RST;
      sync2_ff      <= SYN_RST;
      tick_d_ff     <= 1'b0;
      state_ff      <= RSC_DELAY;
      cause_ff      <= POR_MASK;
      usb_en_ff     <= 1'b0;
      cmp_en_ff     <= 1'b0;
      mcd_en_ff     <= 1'b0;
      vdd_sel_ff    <= 1'b1;
      rdata_ff      <= NO_CAUSE;
      core_rst_b_ff <= 1'b0;
    end else begin
      sync1_ff      <= {sysclk_edge_toggle, supply_below_threshold, comparator_out, vbus_level, rst_pin_in_b};
      sync2_ff      <= sync1_ff;
      tick_d_ff     <= sync2_ff[S_TICK];
      state_ff      <= nxt_state;
      cause_ff      <= nxt_cause;
      usb_en_ff     <= nxt_usb_en;
      cmp_en_ff     <= nxt_cmp_en;
      mcd_en_ff     <= nxt_mcd_en;
      vdd_sel_ff    <= nxt_vdd_sel;
      rdata_ff      <= nxt_rdata;
      core_rst_b_ff <= (nxt_state == RSC_RUN);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_SW_FORCE: assert property (
    (state_ff == RSC_RUN && src_vec == (8'h01 << SW_BIT)) |=> state_ff == RSC_HOLD && cause_ff[SW_BIT] && !core_reset_b)
    else $error("software force did not reset");
  AST_ONE_CAUSE: assert property (
    (state_ff == RSC_RUN && src_vec != NO_CAUSE) |=> $onehot(cause_ff) && ((cause_ff & $past(src_vec)) != NO_CAUSE))
    else $error("cause flags not replaced by newest source");
  AST_PIN_QUAL: assert property (
    (state_ff == RSC_RUN && pin_done && !src_vec[POR_BIT]) |=> cause_ff[PIN_BIT] && state_ff == RSC_HOLD)
    else $error("qualified pin low did not reset");
  AST_DELAY_MIN: assert property (
    (state_ff == RSC_HOLD ##1 state_ff == RSC_DELAY) |-> !core_reset_b [*8])
    else $error("core released too early");
  AST_MCD: assert property (
    (state_ff == RSC_RUN && mcd_en_ff && mcd_done) |=> state_ff == RSC_HOLD)
    else $error("clock loss did not reset");
  AST_RMW: assert property (
    (sfr_rd && reg_hit && sfr_rmw) |=> sfr_rdata[MCD_BIT] == $past(mcd_en_ff) && sfr_rdata[CMP_BIT] == $past(cmp_en_ff))
    else $error("rmw read returned flags");
  AST_READ_FLAG: assert property (
    (sfr_rd && reg_hit && !sfr_rmw) |=> sfr_rdata == $past(cause_ff))
    else $error("flag read mismatch");
  AST_PIN_UNDRIVEN: assert property (
    (state_ff != RSC_RUN) |-> rst_pin_oe_b)
    else $error("reset pin driven by internal reset");
  AST_USB: assert property (
    (state_ff == RSC_RUN && usb_en_ff && usb_bus_reset && src_vec == (8'h01 << USB_BIT)) |=> cause_ff[USB_BIT])
    else $error("usb reset not recorded");
  AST_ENA_WR: assert property (
    (wr_hit && state_ff == RSC_RUN && src_vec == NO_CAUSE) |=> mcd_en_ff == $past(sfr_wdata[MCD_BIT]))
    else $error("enable write lost");
endmodule // rsc_reset_source_control

/* rtl/rsc_pkg.sv */
// Shared constants for the reset source control block
package rsc_pkg;
  // Special function register address
  localparam logic [7:0] RSC_ADDR      = 8'hEF;
  // Bit positions within the register
  localparam int         USB_BIT       = 7;
  localparam int         MEM_BIT       = 6;
  localparam int         CMP_BIT       = 5;
  localparam int         SW_BIT        = 4;
  localparam int         WDT_BIT       = 3;
  localparam int         MCD_BIT       = 2;
  localparam int         POR_BIT       = 1;
  localparam int         PIN_BIT       = 0;
  localparam logic [7:0] NO_CAUSE      = 8'h00;
  localparam logic [7:0] POR_MASK      = 8'h02;
  // Timing
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         PIN_LOW_NS    = 15000;
  localparam int         EXEC_DELAY_NS = 5000;
  localparam int         MCD_TIMEOUT_NS = 220000;
  localparam int         PIN_LOW_CYC   = (PIN_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         EXEC_DELAY_CYC = (EXEC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         MCD_TIMEOUT_CYC = MCD_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int         PIN_CNT_W     = 11;
  localparam int         DLY_CNT_W     = 9;
  localparam int         MCD_CNT_W     = 16;
  // Sequencer states, Gray along run, hold, delay
  typedef enum logic [1:0] {
    RSC_RUN   = 2'b00,
    RSC_HOLD  = 2'b01,
    RSC_DELAY = 2'b11
  } rsc_state_t;
endpackage

/* rtl/rsc_cnt.sv */
// Saturating cycle counter with clear, flags when its limit is reached
`timescale 1ns/1ps
module rsc_cnt #(
  parameter int               WIDTH = 8,
  parameter logic [WIDTH-1:0] LIMIT = '1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Control
  input  wire logic clear,
  // Status
  output logic      done
);
  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;

  assign done = (cnt_ff == LIMIT);

  always_comb begin
    nxt_cnt = cnt_ff;
    if (clear) begin
      nxt_cnt = '0;
    end else if (!done) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule // rsc_cnt

/* tb/rsc_src_model.sv */
// Far-side model: reset pin with pull-up and monitored clock edge source
`timescale 1ns/1ps
module rsc_src_model (
  // Clock
  input  wire logic clk,
  // Controls from the bench
  input  wire logic pin_low,
  input  wire logic clk_stop,
  // Device pin drive
  input  wire logic rst_pin_out,
  input  wire logic rst_pin_oe_b,
  // To the device
  output logic      rst_pin_in_b,
  output logic      sysclk_edge_toggle
);
  // Pull-up wins unless held low outside or driven by the device
  assign rst_pin_in_b = pin_low ? 1'b0 : (rst_pin_oe_b ? 1'b1 : rst_pin_out);
  initial sysclk_edge_toggle = 1'b0;
  always @(posedge clk) begin
    if (!clk_stop) sysclk_edge_toggle <= ~sysclk_edge_toggle;
  end
endmodule // rsc_src_model

/* tb/rsc_reset_source_control_bench.sv */
// Self-checking bench for the reset source control block
`timescale 1ns/1ps
module rsc_reset_source_control_bench;
  import rsc_pkg::*;
  logic       clk;
  logic       rst_b;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic       sfr_rmw;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       usb_bus_reset;
  logic       vbus_level;
  logic       vbus_pol;
  logic       comparator_out;
  logic       watchdog_timeout;
  logic       memory_access_error;
  logic       supply_below_threshold;
  logic       pin_low;
  logic       clk_stop;
  logic       rst_pin_in_b;
  logic       edge_toggle;
  logic       rst_pin_out;
  logic       rst_pin_oe_b;
  logic       core_reset_b;
  logic [7:0] d;
  int         n;
  int         n_errors;
  int         num_checks;
  int         cycles;

  rsc_reset_source_control #(.MCD_CYCLES(50)) dut (
    .clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rmw(sfr_rmw), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .rst_pin_in_b(rst_pin_in_b), .usb_bus_reset(usb_bus_reset), .vbus_level(vbus_level),
    .bus_supply_polarity_select(vbus_pol), .comparator_out(comparator_out),
    .watchdog_timeout(watchdog_timeout), .memory_access_error(memory_access_error),
    .supply_below_threshold(supply_below_threshold), .sysclk_edge_toggle(edge_toggle),
    .rst_pin_out(rst_pin_out), .rst_pin_oe_b(rst_pin_oe_b), .core_reset_b(core_reset_b));

  rsc_src_model model (
    .clk(clk), .pin_low(pin_low), .clk_stop(clk_stop), .rst_pin_out(rst_pin_out),
    .rst_pin_oe_b(rst_pin_oe_b), .rst_pin_in_b(rst_pin_in_b), .sysclk_edge_toggle(edge_toggle));

  task automatic close_out();
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    sfr_addr  <= a;
    sfr_wdata <= v;
    sfr_wr    <= 1'b1;
    @(posedge clk);
    sfr_wr    <= 1'b0;
  endtask

  task automatic sfr_read(input logic [7:0] a, input logic rmw);
    @(posedge clk);
    sfr_addr <= a;
    sfr_rd   <= 1'b1;
    sfr_rmw  <= rmw;
    @(posedge clk);
    sfr_rd   <= 1'b0;
    sfr_rmw  <= 1'b0;
    #1 d = sfr_rdata;
  endtask

  // Bounded wait for the core reset to reach a level
  task automatic wait_core(input logic v, output int cnt);
    cnt = 0;
    while (core_reset_b !== v && cnt < 3000) begin
      @(posedge clk);
      #1 cnt++;
    end
    check("core_reset_b", {7'h0, v}, {7'h0, core_reset_b});
  endtask

  task automatic set_src(input int idx, input logic v);
    case (idx)
      1: comparator_out <= ~v;
      2: watchdog_timeout <= v;
      3: memory_access_error <= v;
      4: usb_bus_reset <= v;
      5: vbus_level <= v;
      6: clk_stop <= v;
      7: pin_low <= v;
      8: supply_below_threshold <= v;
      9: vbus_pol <= ~v;
      default: ;
    endcase
  endtask

  task automatic run_reset(input logic [7:0] en, input int idx, input logic [7:0] exp, input logic [7:0] mask);
    int k;
    sfr_write(RSC_ADDR, en);
    set_src(idx, 1'b1);
    wait_core(1'b0, k);
    check("force latency", 8'h01, {7'h0, (idx != 0 || k <= 2)});
    check("rst_pin_oe_b", 8'h01, {7'h0, rst_pin_oe_b});
    check("rst_pin_out", 8'h00, {7'h0, rst_pin_out});
    @(posedge clk);
    set_src(idx, 1'b0);
    wait_core(1'b1, k);
    check("release delay", 8'h01, {7'h0, (k >= EXEC_DELAY_CYC)});
    sfr_read(RSC_ADDR, 1'b0);
    check("cause flags", exp, d & mask);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  initial begin
    rst_b = 1'b0; sfr_addr = 8'h00; sfr_wr = 1'b0; sfr_rd = 1'b0; sfr_rmw = 1'b0;
    sfr_wdata = 8'h00; usb_bus_reset = 1'b0; vbus_level = 1'b0; vbus_pol = 1'b1;
    comparator_out = 1'b1; watchdog_timeout = 1'b0; memory_access_error = 1'b0;
    supply_below_threshold = 1'b0; pin_low = 1'b0; clk_stop = 1'b0;
    n_errors = 0; num_checks = 0; cycles = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    wait_core(1'b1, n);
    check("power-on delay", 8'h01, {7'h0, (n >= EXEC_DELAY_CYC)});
    sfr_read(RSC_ADDR, 1'b0);
    check("power-on flag", POR_MASK, d & POR_MASK);
    sfr_read(RSC_ADDR, 1'b1);
    check("stored enables", POR_MASK, d & 8'hB6);
    sfr_read(8'h00, 1'b0);
    check("unmapped read", 8'h00, d);
    // Disabled sources and a zero force bit must not reset
    sfr_write(8'hEE, 8'h10);
    sfr_write(RSC_ADDR, 8'h00);
    usb_bus_reset <= 1'b1;
    comparator_out <= 1'b0;
    supply_below_threshold <= 1'b1;
    clk_stop <= 1'b1;
    repeat (60) @(posedge clk);
    #1 check("no reset", 8'h01, {7'h0, core_reset_b});
    @(posedge clk);
    usb_bus_reset <= 1'b0;
    comparator_out <= 1'b1;
    supply_below_threshold <= 1'b0;
    clk_stop <= 1'b0;
    run_reset(8'h12, 0, 8'h10, 8'hFF);
    sfr_write(RSC_ADDR, 8'h22);
    sfr_read(RSC_ADDR, 1'b1);
    check("rmw enables", 8'h22, d & 8'hB6);
    sfr_read(RSC_ADDR, 1'b0);
    check("rmw flags", 8'h10, d);
    run_reset(8'h22, 1, 8'h20, 8'hFF);
    run_reset(8'h02, 2, 8'h08, 8'hFF);
    run_reset(8'h02, 3, 8'h40, 8'hFF);
    run_reset(8'h82, 4, 8'h80, 8'hFF);
    run_reset(8'h82, 5, 8'h80, 8'hFF);
    run_reset(8'h82, 9, 8'h80, 8'hFF);
    run_reset(8'h06, 6, 8'h04, 8'hFF);
    run_reset(8'h02, 7, 8'h01, 8'hFF);
    run_reset(8'h02, 8, 8'h02, POR_MASK);
    close_out();
  end
endmodule // rsc_reset_source_control_bench
